// [rtl/srw_pkg.sv]
package srw_pkg;
  // register offsets on the internal peripheral bus (byte offsets)
  localparam logic [9:0]  OFS_WRITE_CEILING = 10'h112;
  localparam logic [9:0]  OFS_IRQ_SET       = 10'h114;
  localparam logic [9:0]  OFS_CLEAR_PERMIT  = 10'h116;
  localparam logic [15:0] RST_WRITE_CEILING = 16'h0000;
  localparam logic [15:0] RST_IRQ_SOURCE    = 16'h0000;
  localparam logic [15:0] RST_CLEAR_PERMIT  = 16'h0000;
  // writable fields
  localparam logic [15:0] MASK_CEILING      = 16'h7ffc;
  localparam logic [15:0] MASK_IRQ          = 16'hfffe;
  localparam int          REGION_SEL_BIT    = 15;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } srw_bus_req_s;

  typedef struct packed {
    logic [15:0] shared_ram_offset;
    logic [3:0]  be;
    logic [31:0] wdata;
  } srw_win_wr_s;
endpackage

// [rtl/srw_top.sv]
// What this block does
// - window write with address bit 15 set compares offset [14:2] to ceiling
// - offset strictly below the ceiling: addressed bytes are written to RAM
// - offset at or above the ceiling: write suppressed, RAM unchanged
// - writing one to an interrupt set bit sets that source bit
// - writing zero to an interrupt set bit leaves the source bit alone
// - reading the set register returns current interrupt source contents
// - clear permit bit zero: host clear attempts on that bit ignored
// - clear permit bit one: host writing one clears that source bit
// - set at 114h, permit at 116h, 16 bits, reset 0, bit 0 reserved
// - address bit 15 selects region one; offset relative to its base
module srw_top
  import srw_pkg::*;
(
  // clock, reset, enable
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_N_I,
  input  wire logic              CE_I,
  // internal peripheral bus
  input  wire srw_bus_req_s      BUS_REQ_I,
  output logic [15:0]            BUS_RDATA_O,
  output logic                   BUS_RVALID_O,
  // window write attempts
  input  wire srw_win_wr_s       WIN_WR_I,
  input  wire logic              WIN_WR_VALID_I,
  input  wire logic [21:0]       REGION_ONE_BASE_I,
  // host clear of interrupt source
  input  wire logic              HOST_CLR_I,
  input  wire logic [15:0]       HOST_CLR_DATA_I,
  // closely coupled data ram write port
  output logic                   RAM_WE_O,
  output logic [3:0]             RAM_BE_O,
  output logic [21:0]            RAM_WORD_ADDR_O,
  output logic [31:0]            RAM_WDATA_O,
  output logic                   WIN_WR_BLOCKED_O,
  // interrupt source state to host
  output logic [15:0]            IRQ_SOURCE_O
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] write_ceiling, next_write_ceiling;
  logic [15:0] irq_source, next_irq_source;
  logic [15:0] clear_permit, next_clear_permit;
  logic [15:0] rdata, next_rdata;
  logic        rvalid, next_rvalid;
  logic [15:0] be_mask;

  assign be_mask = {{8{BUS_REQ_I.be[1]}}, {8{BUS_REQ_I.be[0]}}};

  always_comb begin
    next_write_ceiling = write_ceiling;
    next_clear_permit  = clear_permit;
    next_rdata         = 16'h0000;
    next_rvalid        = 1'b0;
    if (BUS_REQ_I.wr) begin
      unique case (BUS_REQ_I.addr)
        OFS_WRITE_CEILING: begin
          next_write_ceiling = (write_ceiling & ~(be_mask & MASK_CEILING)) |
                               (BUS_REQ_I.wdata & be_mask & MASK_CEILING);
        end
        OFS_CLEAR_PERMIT: begin
          next_clear_permit = (clear_permit & ~(be_mask & MASK_IRQ)) |
                              (BUS_REQ_I.wdata & be_mask & MASK_IRQ);
        end
        default: begin
        end
      endcase
    end
    if (BUS_REQ_I.rd) begin
      next_rvalid = 1'b1;
      unique case (BUS_REQ_I.addr)
        OFS_WRITE_CEILING: next_rdata = write_ceiling;
        OFS_IRQ_SET:       next_rdata = irq_source;
        OFS_CLEAR_PERMIT:  next_rdata = clear_permit;
        default:           next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      write_ceiling <= RST_WRITE_CEILING;
      clear_permit  <= RST_CLEAR_PERMIT;
      rdata         <= 16'h0000;
      rvalid        <= 1'b0;
    end else if (CE_I) begin
      write_ceiling <= next_write_ceiling;
      clear_permit  <= next_clear_permit;
      rdata         <= next_rdata;
      rvalid        <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt source
  logic [15:0] set_bits, clr_bits;

  always_comb begin
    set_bits = 16'h0000;
    if (BUS_REQ_I.wr && BUS_REQ_I.addr == OFS_IRQ_SET) begin
      set_bits = BUS_REQ_I.wdata & be_mask & MASK_IRQ;
    end
    // clear only where permitted; unpermitted bits ignore the attempt
    clr_bits = HOST_CLR_I ? (HOST_CLR_DATA_I & clear_permit & MASK_IRQ)
                          : 16'h0000;
    // set applied after clear so a coincident event is kept
    next_irq_source = (irq_source & ~clr_bits) | set_bits;
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_source <= RST_IRQ_SOURCE;
    end else if (CE_I) begin
      irq_source <= next_irq_source;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // window write gate
  logic        win_region_one;
  logic [12:0] win_offset;
  logic        win_allow;
  logic        next_ram_we, ram_we;
  logic        next_blocked, blocked;
  logic [3:0]  ram_be, next_ram_be;
  logic [21:0] ram_addr, next_ram_addr;
  logic [31:0] ram_wdata, next_ram_wdata;

  always_comb begin
    win_region_one = WIN_WR_I.shared_ram_offset[REGION_SEL_BIT];
    win_offset     = WIN_WR_I.shared_ram_offset[14:2];
    // unsigned compare, strictly below
    win_allow      = win_offset < write_ceiling[14:2];
    next_ram_we    = WIN_WR_VALID_I && win_region_one && win_allow &&
                     (|WIN_WR_I.be);
    next_blocked   = WIN_WR_VALID_I && win_region_one && !win_allow;
    // address and data hold until the next accepted write
    next_ram_be    = ram_be;
    next_ram_addr  = ram_addr;
    next_ram_wdata = ram_wdata;
    if (next_ram_we) begin
      next_ram_be    = WIN_WR_I.be;
      // word address = region base + window word offset
      next_ram_addr  = REGION_ONE_BASE_I + {9'h000, win_offset};
      next_ram_wdata = WIN_WR_I.wdata;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ram_we    <= 1'b0;
      blocked   <= 1'b0;
      ram_be    <= 4'h0;
      ram_addr  <= 22'h000000;
      ram_wdata <= 32'h00000000;
    end else if (CE_I) begin
      ram_we    <= next_ram_we;
      blocked   <= next_blocked;
      ram_be    <= next_ram_be;
      ram_addr  <= next_ram_addr;
      ram_wdata <= next_ram_wdata;
    end
  end

  assign BUS_RDATA_O      = rdata;
  assign BUS_RVALID_O     = rvalid;
  assign RAM_WE_O         = ram_we;
  assign RAM_BE_O         = ram_be;
  assign RAM_WORD_ADDR_O  = ram_addr;
  assign RAM_WDATA_O      = ram_wdata;
  assign WIN_WR_BLOCKED_O = blocked;
  assign IRQ_SOURCE_O     = irq_source;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_gate_pass;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (CE_I && WIN_WR_VALID_I && WIN_WR_I.shared_ram_offset[15] &&
     (|WIN_WR_I.be) &&
     WIN_WR_I.shared_ram_offset[14:2] < write_ceiling[14:2]) |=> RAM_WE_O;
  endproperty
  a_gate_pass: assert property (p_gate_pass)
    else $error("allowed window write not issued");

  property p_gate_block;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (CE_I && WIN_WR_VALID_I && WIN_WR_I.shared_ram_offset[15] &&
     WIN_WR_I.shared_ram_offset[14:2] >= write_ceiling[14:2])
    |=> !RAM_WE_O && WIN_WR_BLOCKED_O;
  endproperty
  a_gate_block: assert property (p_gate_block)
    else $error("write above ceiling reached ram");

  property p_region_zero;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (CE_I && !WIN_WR_I.shared_ram_offset[15]) |=> !RAM_WE_O;
  endproperty
  a_region_zero: assert property (p_region_zero)
    else $error("region zero write passed this gate");

  property p_set;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (CE_I && BUS_REQ_I.wr && BUS_REQ_I.addr == OFS_IRQ_SET)
    |=> ((IRQ_SOURCE_O & $past(set_bits)) == $past(set_bits));
  endproperty
  a_set: assert property (p_set)
    else $error("set bit not reflected in source");

  property p_no_clear_unpermitted;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I |=> ((($past(irq_source) & ~$past(clear_permit)) & ~irq_source)
              == 16'h0000);
  endproperty
  a_no_clear_unpermitted: assert property (p_no_clear_unpermitted)
    else $error("unpermitted source bit was cleared");

  property p_clear;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (CE_I && HOST_CLR_I && !(BUS_REQ_I.wr && BUS_REQ_I.addr == OFS_IRQ_SET))
    |=> ((irq_source & $past(HOST_CLR_DATA_I) & $past(clear_permit))
         == 16'h0000);
  endproperty
  a_clear: assert property (p_clear)
    else $error("permitted clear did not clear");

  property p_readback;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (CE_I && BUS_REQ_I.rd && BUS_REQ_I.addr == OFS_IRQ_SET)
    |=> BUS_RVALID_O && BUS_RDATA_O == $past(irq_source);
  endproperty
  a_readback: assert property (p_readback)
    else $error("set register read not source");

  property p_reserved;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    1'b1 |-> !irq_source[0] && !clear_permit[0] &&
             (write_ceiling & ~MASK_CEILING) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit became set");

  sequence s_allowed_write;
    CE_I && WIN_WR_VALID_I && WIN_WR_I.shared_ram_offset[REGION_SEL_BIT] &&
    (|WIN_WR_I.be) &&
    (WIN_WR_I.shared_ram_offset[14:2] < write_ceiling[14:2]);
  endsequence

  sequence s_idle_window;
    CE_I && !(WIN_WR_VALID_I && WIN_WR_I.shared_ram_offset[REGION_SEL_BIT]);
  endsequence

  property p_ram_addr;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    s_allowed_write |=> RAM_WORD_ADDR_O == $past(REGION_ONE_BASE_I) +
                        {9'h000, $past(WIN_WR_I.shared_ram_offset[14:2])};
  endproperty
  a_ram_addr: assert property (p_ram_addr)
    else $error("ram word address not base plus offset");

  property p_ram_data;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    s_allowed_write |=> RAM_WDATA_O == $past(WIN_WR_I.wdata) &&
                        RAM_BE_O == $past(WIN_WR_I.be);
  endproperty
  a_ram_data: assert property (p_ram_data)
    else $error("ram data or lanes not the window bytes");

  property p_idle_window;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    s_idle_window |=> !RAM_WE_O && !WIN_WR_BLOCKED_O;
  endproperty
  a_idle_window: assert property (p_idle_window)
    else $error("window pulse without a region one attempt");

  property p_set_only;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (CE_I && !HOST_CLR_I && BUS_REQ_I.wr && BUS_REQ_I.addr == OFS_IRQ_SET)
    |=> IRQ_SOURCE_O == ($past(irq_source) | $past(set_bits));
  endproperty
  a_set_only: assert property (p_set_only)
    else $error("zero in set register changed a source bit");

  property p_set_wins;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (CE_I && HOST_CLR_I && BUS_REQ_I.wr && BUS_REQ_I.addr == OFS_IRQ_SET)
    |=> (IRQ_SOURCE_O & $past(set_bits)) == $past(set_bits) &&
        (IRQ_SOURCE_O & $past(HOST_CLR_DATA_I) & $past(clear_permit) &
         ~$past(set_bits)) == 16'h0000;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("coincident clear beat the set");

  property p_read_idle;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (CE_I && !BUS_REQ_I.rd) |=> !BUS_RVALID_O && BUS_RDATA_O == 16'h0000;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read answer without a read request");

  property p_ceiling_write;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (CE_I && BUS_REQ_I.wr && BUS_REQ_I.addr == OFS_WRITE_CEILING &&
     BUS_REQ_I.be == 2'h3)
    |=> write_ceiling == ($past(BUS_REQ_I.wdata) & MASK_CEILING);
  endproperty
  a_ceiling_write: assert property (p_ceiling_write)
    else $error("ceiling write not masked to its field");

  property p_permit_low_write;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (CE_I && BUS_REQ_I.wr && BUS_REQ_I.addr == OFS_CLEAR_PERMIT &&
     BUS_REQ_I.be == 2'h1)
    |=> clear_permit[15:8] == $past(clear_permit[15:8]) &&
        clear_permit[7:0] == ($past(BUS_REQ_I.wdata[7:0]) & MASK_IRQ[7:0]);
  endproperty
  a_permit_low_write: assert property (p_permit_low_write)
    else $error("permit byte lane write wrong");

endmodule

// [verif/srw_ram_model.sv]
// behavioural closely coupled data ram behind the window write port
module srw_ram_model (
  // clock
  input  wire logic        clk_i,
  // write port from the window gate
  input  wire logic        we_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [21:0] addr_i,
  input  wire logic [31:0] wdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [21:0]];
  int          writes = 0;
  // only the enabled lanes change; nothing moves without we
  always @(posedge clk_i) begin
    if (we_i === 1'b1) begin
      writes <= writes + 1;
      for (int b = 0; b < 4; b++) begin
        if (be_i[b]) begin
          mem[addr_i][8*b +: 8] <= wdata_i[8*b +: 8];
        end
      end
    end
  end
endmodule

// [verif/srw_top_test.sv]
module srw_top_test
  import srw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [21:0] BASE = 22'h001000;
  logic         clk;
  logic         rst_n;
  logic         win_v;
  logic         hclr;
  srw_bus_req_s req;
  srw_win_wr_s  win;
  logic [15:0]  hdata;
  logic [15:0]  rdata;
  logic [15:0]  src;
  logic         rvalid;
  logic         we;
  logic         blk;
  logic [3:0]   be;
  logic [21:0]  waddr;
  logic [31:0]  wd;
  int           fails;
  int           comparisons;
  srw_top u_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
    .BUS_REQ_I(req), .BUS_RDATA_O(rdata), .BUS_RVALID_O(rvalid),
    .WIN_WR_I(win), .WIN_WR_VALID_I(win_v), .REGION_ONE_BASE_I(BASE),
    .HOST_CLR_I(hclr), .HOST_CLR_DATA_I(hdata), .RAM_WE_O(we),
    .RAM_BE_O(be), .RAM_WORD_ADDR_O(waddr), .RAM_WDATA_O(wd),
    .WIN_WR_BLOCKED_O(blk), .IRQ_SOURCE_O(src));
  srw_ram_model u_ram (.clk_i(clk), .we_i(we), .be_i(be), .addr_i(waddr),
    .wdata_i(wd));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [9:0] a, input logic [1:0] b, input logic [15:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask
  task rd(input logic [9:0] a, input logic [15:0] e);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 2'h3, wdata: 16'h0000};
    @(negedge clk);
    req = '0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rdata", {16'h0, e}, {16'h0, rdata});
    @(negedge clk);
  endtask
  task ww(input logic [15:0] o, input logic e_we, input logic e_blk);
    win = '{shared_ram_offset: o, be: 4'h5, wdata: 32'h1234abcd};
    win_v = 1'b1;
    @(negedge clk);
    win_v = 1'b0;
    chk("ram_we", {31'h0, e_we}, {31'h0, we});
    chk("blocked", {31'h0, e_blk}, {31'h0, blk});
    @(negedge clk);
  endtask
  task hc(input logic [15:0] d);
    hdata = d;
    hclr = 1'b1;
    @(negedge clk);
    hclr = 1'b0;
    @(negedge clk);
  endtask
  task summarize;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // whole run is about sixty cycles; generous margin
  initial begin
    #20000;
    fails++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    win = '0;
    win_v = 1'b0;
    hclr = 1'b0;
    hdata = 16'h0000;
    fails = 0;
    comparisons = 0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("irq_source", 32'h0, {16'h0, src});
    rd(OFS_WRITE_CEILING, RST_WRITE_CEILING);
    rd(OFS_IRQ_SET, RST_IRQ_SOURCE);
    rd(OFS_CLEAR_PERMIT, RST_CLEAR_PERMIT);
    ww(16'h8000, 1'b0, 1'b1);
    wr(OFS_WRITE_CEILING, 2'h3, 16'hffff);
    rd(OFS_WRITE_CEILING, MASK_CEILING);
    wr(10'h118, 2'h3, 16'hffff);
    rd(10'h118, 16'h0000);
    wr(OFS_WRITE_CEILING, 2'h3, 16'h0040);
    // last word below the ceiling, then the ceiling word itself
    ww(16'h803c, 1'b1, 1'b0);
    chk("ram_addr", {10'h0, BASE + 22'h00f}, {10'h0, waddr});
    chk("ram_be", 32'h5, {28'h0, be});
    chk("ram_word", 32'h003400cd,
        u_ram.mem[BASE + 22'h00f] & 32'h00ff00ff);
    ww(16'h8040, 1'b0, 1'b1);
    chk("ram_writes", 32'h1, u_ram.writes);
    ww(16'h003c, 1'b0, 1'b0);
    wr(OFS_IRQ_SET, 2'h3, 16'h0007);
    rd(OFS_IRQ_SET, 16'h0006);
    wr(OFS_IRQ_SET, 2'h3, 16'h0000);
    rd(OFS_IRQ_SET, 16'h0006);
    // bits 1 and 3 latched flags, bit 2 level flag
    wr(OFS_CLEAR_PERMIT, 2'h1, 16'hff0a);
    rd(OFS_CLEAR_PERMIT, 16'h000a);
    hc(16'h0006);
    chk("irq_source", 32'h4, {16'h0, src});
    // set and permitted clear of bit 3 in the same cycle
    hdata = 16'h0008;
    hclr = 1'b1;
    req = '{wr: 1'b1, rd: 1'b0, addr: OFS_IRQ_SET, be: 2'h3,
           wdata: 16'h0008};
    @(negedge clk);
    hclr = 1'b0;
    req = '0;
    chk("irq_source", 32'hc, {16'h0, src});
    // reset again in mid run: every register back to its reset value
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("irq_source", 32'h0, {16'h0, src});
    rd(OFS_WRITE_CEILING, RST_WRITE_CEILING);
    rd(OFS_CLEAR_PERMIT, RST_CLEAR_PERMIT);
    summarize();
  end
endmodule
